// *** hdl/amp_event_flag_pkg.sv ***
package amp_event_flag_pkg;

    // register map, byte addresses of the control port
    localparam logic [15:0] ADDR_EVENT_FLAGS_TWO = 16'h200c;
    localparam logic [15:0] ADDR_EVENT_FLAGS_THREE = 16'h200d;
    localparam logic [15:0] ADDR_UNMASK_TWO = 16'h2011;
    localparam logic [15:0] ADDR_UNMASK_THREE = 16'h2012;

    // reset values
    localparam logic [7:0] RESET_FLAGS = 8'h00;
    localparam logic [7:0] RESET_UNMASK = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // implemented bit positions; the others are unused and read as zero
    localparam logic [7:0] VALID_TWO = 8'hf7;
    localparam logic [7:0] VALID_THREE = 8'h3f;

    // second flag register fields
    localparam int HEAT_WARN_LVL2_START_BIT = 7;
    localparam int HEAT_WARN_LVL2_STOP_BIT = 6;
    localparam int SPEAKER_MONITOR_FAULT_BIT = 5;
    localparam int CLOCK_MONITOR_FAULT_BIT = 4;
    localparam int PORT_CLOCK_RECOVER_BIT = 2;
    localparam int PORT_CLOCK_FAULT_BIT = 1;
    localparam int PORT_DATA_FAULT_BIT = 0;

    // third flag register fields
    localparam int POWERUP_COMPLETE_BIT = 5;
    localparam int POWERDOWN_COMPLETE_BIT = 4;
    localparam int HV_SUPPLY_UNDERVOLT_BIT = 3;
    localparam int BATTERY_UNDERVOLT_BIT = 2;
    localparam int HEADROOM_TRACK_START_BIT = 1;
    localparam int HEADROOM_TRACK_STOP_BIT = 0;

    // number of flag bit positions handled in one bank, unused positions included
    localparam int FLAG_COUNT = 16;

endpackage

// *** hdl/amp_event_flag_bank.sv ***
`timescale 1ns/1ps
// Operation
// - bit 7 of register two latches a level-2 heat warning start rise when unmasked
// - bit 6 of register two latches a level-2 heat warning stop rise when unmasked
// - bit 5 of register two latches a speaker monitor fault rise when unmasked
// - bit 4 of register two latches a clock monitor fault rise when unmasked
// - bit 2 of register two latches a port clock recovery rise when unmasked
// - bit 1 of register two latches a port clock fault rise when unmasked
// - bit 0 of register two latches a port data fault rise when unmasked
// - bit 5 of register three latches a power-up complete rise when unmasked
// - bit 4 of register three latches a power-down complete rise when unmasked
// - bit 3 of register three latches a high-voltage supply undervoltage rise
// - bit 2 of register three latches a battery undervoltage rise when unmasked
// - bit 1 of register three latches a headroom tracking start rise when unmasked
// - bit 0 of register three latches a headroom tracking stop rise when unmasked
// - a masked flag stays zero whatever its raw event does
// - a flag drops on its own clear or when its unmask bit is cleared; later rises set it again
// - with the interrupt enabled, any flag rising edge raises an interrupt
// - register two is read-only, resets to zero, bit 3 unused
// - register three is read-only, resets to zero, bits 7 and 6 unused
// - unmask bits for register two sit in a read-write mirror register, reset zero
module amp_event_flag_bank
    import amp_event_flag_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    // raw event levels from the amplifier core
    input wire logic heatWarnLvl2StartRaw,
    input wire logic heatWarnLvl2StopRaw,
    input wire logic speakerMonitorFaultRaw,
    input wire logic clockMonitorFaultRaw,
    input wire logic portClockRecoverRaw,
    input wire logic portClockFaultRaw,
    input wire logic portDataFaultRaw,
    input wire logic powerupCompleteRaw,
    input wire logic powerdownCompleteRaw,
    input wire logic hvSupplyUndervoltRaw,
    input wire logic batteryUndervoltRaw,
    input wire logic headroomTrackStartRaw,
    input wire logic headroomTrackStopRaw,
    // per-flag clear pulses, bit positions as in the flag registers
    input wire logic [7:0] clearTwo,
    input wire logic [7:0] clearThree,
    input wire logic irqEnable,
    // control port register access
    input wire logic [15:0] regAddr,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regWdata,
    output logic [7:0] regRdata,
    output logic [7:0] eventFlagsTwo,
    output logic [7:0] eventFlagsThree,
    output logic irq
);

    logic [7:0] rawTwo;
    logic [7:0] rawThree;
    logic [FLAG_COUNT-1:0] rawAll;
    logic [FLAG_COUNT-1:0] rawPrev;
    logic [FLAG_COUNT-1:0] clearAll;
    logic [FLAG_COUNT-1:0] unmaskAll;
    logic [FLAG_COUNT-1:0] validAll;
    logic [FLAG_COUNT-1:0] flagAll;
    logic [FLAG_COUNT-1:0] next_flagAll;
    logic [FLAG_COUNT-1:0] riseAll;
    logic [7:0] unmaskTwo;
    logic [7:0] unmaskThree;
    logic [7:0] next_regRdata;

    // pack the raw events into their register positions
    always_comb begin
        rawTwo = 8'h00;
        rawThree = 8'h00;
        rawTwo[HEAT_WARN_LVL2_START_BIT] = heatWarnLvl2StartRaw;
        rawTwo[HEAT_WARN_LVL2_STOP_BIT] = heatWarnLvl2StopRaw;
        rawTwo[SPEAKER_MONITOR_FAULT_BIT] = speakerMonitorFaultRaw;
        rawTwo[CLOCK_MONITOR_FAULT_BIT] = clockMonitorFaultRaw;
        rawTwo[PORT_CLOCK_RECOVER_BIT] = portClockRecoverRaw;
        rawTwo[PORT_CLOCK_FAULT_BIT] = portClockFaultRaw;
        rawTwo[PORT_DATA_FAULT_BIT] = portDataFaultRaw;
        rawThree[POWERUP_COMPLETE_BIT] = powerupCompleteRaw;
        rawThree[POWERDOWN_COMPLETE_BIT] = powerdownCompleteRaw;
        rawThree[HV_SUPPLY_UNDERVOLT_BIT] = hvSupplyUndervoltRaw;
        rawThree[BATTERY_UNDERVOLT_BIT] = batteryUndervoltRaw;
        rawThree[HEADROOM_TRACK_START_BIT] = headroomTrackStartRaw;
        rawThree[HEADROOM_TRACK_STOP_BIT] = headroomTrackStopRaw;
    end

    // one flat bank keeps the per-flag logic in a single loop
    assign rawAll = {rawThree, rawTwo};
    assign clearAll = {clearThree, clearTwo};
    assign unmaskAll = {unmaskThree, unmaskTwo};
    assign validAll = {VALID_THREE, VALID_TWO};

    // previous raw levels for edge detection
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rawPrev <= '0;
        end else begin
            rawPrev <= rawAll;
        end
    end

    // per-flag next state; a rise in the clearing cycle still sets the flag
    // so that no event is lost to a badly timed clear
    genvar gi;
    generate
        for (gi = 0; gi < FLAG_COUNT; gi++) begin : gFlag
            assign riseAll[gi] = rawAll[gi] & ~rawPrev[gi];
            always_comb begin
                if (!validAll[gi]) begin
                    next_flagAll[gi] = 1'b0;
                end else if (!unmaskAll[gi]) begin
                    next_flagAll[gi] = 1'b0;
                end else if (riseAll[gi]) begin
                    next_flagAll[gi] = 1'b1;
                end else if (clearAll[gi]) begin
                    next_flagAll[gi] = 1'b0;
                end else begin
                    next_flagAll[gi] = flagAll[gi];
                end
            end
        end
    endgenerate

    // flag storage, read-only from the register side
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            flagAll <= {RESET_FLAGS, RESET_FLAGS};
        end else begin
            flagAll <= next_flagAll;
        end
    end

    assign eventFlagsTwo = flagAll[7:0];
    assign eventFlagsThree = flagAll[15:8];

    // unmask registers; bits with no flag behind them are never stored
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            unmaskTwo <= RESET_UNMASK;
            unmaskThree <= RESET_UNMASK;
        end else if (regWrite) begin
            if (regAddr == ADDR_UNMASK_TWO) begin
                unmaskTwo <= regWdata & VALID_TWO;
            end
            if (regAddr == ADDR_UNMASK_THREE) begin
                unmaskThree <= regWdata & VALID_THREE;
            end
        end
    end

    // read mux; writes to flag addresses fall through and change nothing
    always_comb begin
        next_regRdata = regRdata;
        if (regRead) begin
            unique case (regAddr)
                ADDR_EVENT_FLAGS_TWO: next_regRdata = flagAll[7:0] & VALID_TWO;
                ADDR_EVENT_FLAGS_THREE: next_regRdata = flagAll[15:8] & VALID_THREE;
                ADDR_UNMASK_TWO: next_regRdata = unmaskTwo;
                ADDR_UNMASK_THREE: next_regRdata = unmaskThree;
                default: next_regRdata = READ_UNMAPPED;
            endcase
        end
    end

    // read data is held until the next read so a slow port can sample it
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            regRdata <= READ_UNMAPPED;
        end else begin
            regRdata <= next_regRdata;
        end
    end

    // interrupt pulse in the cycle the new flag first shows; a flag that
    // stays high does not retrigger, so software must clear it to rearm
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            irq <= 1'b0;
        end else begin
            irq <= irqEnable & (|(next_flagAll & ~flagAll));
        end
    end

    // helper: a flag that was low and is now high
    logic [FLAG_COUNT-1:0] flagRose;
    logic [FLAG_COUNT-1:0] rawPrevFlag;
    assign flagRose = flagAll & ~rawPrevFlag;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rawPrevFlag <= '0;
        end else begin
            rawPrevFlag <= flagAll;
        end
    end

    sequence seqWarnStartRise;
        heatWarnLvl2StartRaw && !rawPrev[HEAT_WARN_LVL2_START_BIT];
    endsequence

    sequence seqWarnStartArmed;
        seqWarnStartRise ##0 unmaskTwo[HEAT_WARN_LVL2_START_BIT];
    endsequence

    chk_warn_start_set: assert property (@(posedge core_clk) disable iff (!rst_b)
        seqWarnStartArmed |=> eventFlagsTwo[HEAT_WARN_LVL2_START_BIT])
        else $error("heat warning start flag did not set");

    chk_data_fault_set: assert property (@(posedge core_clk) disable iff (!rst_b)
        (portDataFaultRaw && !rawPrev[PORT_DATA_FAULT_BIT] && unmaskTwo[PORT_DATA_FAULT_BIT])
        |=> eventFlagsTwo[PORT_DATA_FAULT_BIT])
        else $error("port data fault flag did not set");

    chk_headroom_stop_set: assert property (@(posedge core_clk) disable iff (!rst_b)
        (headroomTrackStopRaw && !rawPrev[8 + HEADROOM_TRACK_STOP_BIT]
        && unmaskThree[HEADROOM_TRACK_STOP_BIT])
        |=> eventFlagsThree[HEADROOM_TRACK_STOP_BIT])
        else $error("headroom tracking stop flag did not set");

    chk_warn_stop_set: assert property (@(posedge core_clk) disable iff (!rst_b)
        (heatWarnLvl2StopRaw && !rawPrev[HEAT_WARN_LVL2_STOP_BIT]
        && unmaskTwo[HEAT_WARN_LVL2_STOP_BIT])
        |=> eventFlagsTwo[HEAT_WARN_LVL2_STOP_BIT])
        else $error("heat warning stop flag did not set");

    chk_speaker_fault_set: assert property (@(posedge core_clk) disable iff (!rst_b)
        (speakerMonitorFaultRaw && !rawPrev[SPEAKER_MONITOR_FAULT_BIT]
        && unmaskTwo[SPEAKER_MONITOR_FAULT_BIT])
        |=> eventFlagsTwo[SPEAKER_MONITOR_FAULT_BIT])
        else $error("speaker monitor fault flag did not set");

    chk_monitor_clock_set: assert property (@(posedge core_clk) disable iff (!rst_b)
        (clockMonitorFaultRaw && !rawPrev[CLOCK_MONITOR_FAULT_BIT]
        && unmaskTwo[CLOCK_MONITOR_FAULT_BIT])
        |=> eventFlagsTwo[CLOCK_MONITOR_FAULT_BIT])
        else $error("clock monitor fault flag did not set");

    chk_clock_recover_set: assert property (@(posedge core_clk) disable iff (!rst_b)
        (portClockRecoverRaw && !rawPrev[PORT_CLOCK_RECOVER_BIT]
        && unmaskTwo[PORT_CLOCK_RECOVER_BIT])
        |=> eventFlagsTwo[PORT_CLOCK_RECOVER_BIT])
        else $error("port clock recovery flag did not set");

    chk_port_clock_set: assert property (@(posedge core_clk) disable iff (!rst_b)
        (portClockFaultRaw && !rawPrev[PORT_CLOCK_FAULT_BIT]
        && unmaskTwo[PORT_CLOCK_FAULT_BIT])
        |=> eventFlagsTwo[PORT_CLOCK_FAULT_BIT])
        else $error("port clock fault flag did not set");

    chk_powerup_done_set: assert property (@(posedge core_clk) disable iff (!rst_b)
        (powerupCompleteRaw && !rawPrev[8 + POWERUP_COMPLETE_BIT]
        && unmaskThree[POWERUP_COMPLETE_BIT])
        |=> eventFlagsThree[POWERUP_COMPLETE_BIT])
        else $error("power-up complete flag did not set");

    chk_powerdown_done_set: assert property (@(posedge core_clk) disable iff (!rst_b)
        (powerdownCompleteRaw && !rawPrev[8 + POWERDOWN_COMPLETE_BIT]
        && unmaskThree[POWERDOWN_COMPLETE_BIT])
        |=> eventFlagsThree[POWERDOWN_COMPLETE_BIT])
        else $error("power-down complete flag did not set");

    chk_hv_undervolt_set: assert property (@(posedge core_clk) disable iff (!rst_b)
        (hvSupplyUndervoltRaw && !rawPrev[8 + HV_SUPPLY_UNDERVOLT_BIT]
        && unmaskThree[HV_SUPPLY_UNDERVOLT_BIT])
        |=> eventFlagsThree[HV_SUPPLY_UNDERVOLT_BIT])
        else $error("high-voltage supply undervoltage flag did not set");

    chk_battery_undervolt_set: assert property (@(posedge core_clk) disable iff (!rst_b)
        (batteryUndervoltRaw && !rawPrev[8 + BATTERY_UNDERVOLT_BIT]
        && unmaskThree[BATTERY_UNDERVOLT_BIT])
        |=> eventFlagsThree[BATTERY_UNDERVOLT_BIT])
        else $error("battery undervoltage flag did not set");

    chk_headroom_start_set: assert property (@(posedge core_clk) disable iff (!rst_b)
        (headroomTrackStartRaw && !rawPrev[8 + HEADROOM_TRACK_START_BIT]
        && unmaskThree[HEADROOM_TRACK_START_BIT])
        |=> eventFlagsThree[HEADROOM_TRACK_START_BIT])
        else $error("headroom tracking start flag did not set");

    chk_mask_holds_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
        $past(unmaskAll) == '0 && unmaskAll == '0 |-> flagAll == '0)
        else $error("masked flag went high");

    chk_flag_no_self_drop: assert property (@(posedge core_clk) disable iff (!rst_b)
        (flagAll[0] && unmaskAll[0] && !clearAll[0]) |=> flagAll[0])
        else $error("flag dropped without a clear");

    chk_clear_drops_flag: assert property (@(posedge core_clk) disable iff (!rst_b)
        (flagAll[1] && clearAll[1] && !riseAll[1]) |=> !flagAll[1])
        else $error("clear did not drop flag");

    chk_irq_on_rise: assert property (@(posedge core_clk) disable iff (!rst_b)
        (|flagRose) && $past(irqEnable) |-> irq)
        else $error("flag rose without interrupt");

    chk_irq_one_cycle: assert property (@(posedge core_clk) disable iff (!rst_b)
        irq |-> (|flagRose) ##1 !irq || (|flagRose))
        else $error("interrupt not tied to a new flag");

    chk_unused_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
        (flagAll & ~validAll) == '0 ##1 (flagAll & ~validAll) == '0)
        else $error("unused flag bit set");

    chk_read_two: assert property (@(posedge core_clk) disable iff (!rst_b)
        (regRead && regAddr == ADDR_EVENT_FLAGS_TWO) |=> regRdata[3] == 1'b0
        && regRdata == $past(flagAll[7:0]))
        else $error("wrong read of flag register two");

    chk_read_three: assert property (@(posedge core_clk) disable iff (!rst_b)
        (regRead && regAddr == ADDR_EVENT_FLAGS_THREE) |=> regRdata[7:6] == 2'b00
        && regRdata == $past(flagAll[15:8]))
        else $error("wrong read of flag register three");

    chk_unmask_write: assert property (@(posedge core_clk) disable iff (!rst_b)
        (regWrite && regAddr == ADDR_UNMASK_TWO) |=> unmaskTwo == ($past(regWdata) & VALID_TWO))
        else $error("unmask register two not written");

    chk_irq_gated_off: assert property (@(posedge core_clk) disable iff (!rst_b)
        !irqEnable |=> !irq)
        else $error("interrupt raised while disabled");

    // per-position checks; one copy for every bit of the bank, unused
    // positions included, so a slip in the packing shows up as well
    generate
        for (gi = 0; gi < FLAG_COUNT; gi++) begin : gFlagChk
            // a raw rise on a position that is unmasked and implemented
            sequence seqArmedRise;
                riseAll[gi] && unmaskAll[gi] && validAll[gi];
            endsequence

            // the flag was low at one edge and high at the next
            sequence seqFlagUp;
                !flagAll[gi] ##1 flagAll[gi];
            endsequence

            chk_armed_flag_set: assert property (@(posedge core_clk) disable iff (!rst_b)
                seqArmedRise |=> flagAll[gi])
                else $error("armed rise did not set its flag");

            chk_masked_flag_low: assert property (@(posedge core_clk) disable iff (!rst_b)
                !unmaskAll[gi] |=> !flagAll[gi])
                else $error("masked flag went high");

            chk_flag_has_cause: assert property (@(posedge core_clk) disable iff (!rst_b)
                seqFlagUp |-> $past(riseAll[gi]) && $past(unmaskAll[gi]))
                else $error("flag set without an armed rise");

            chk_flag_holds_set: assert property (@(posedge core_clk) disable iff (!rst_b)
                (flagAll[gi] && unmaskAll[gi] && !clearAll[gi]) |=> flagAll[gi])
                else $error("flag dropped without its clear");

            chk_clear_drops_bit: assert property (@(posedge core_clk) disable iff (!rst_b)
                (flagAll[gi] && clearAll[gi] && !riseAll[gi]) |=> !flagAll[gi])
                else $error("clear left the flag set");
        end
    endgenerate

endmodule

// *** testbench/tb_amp_event_flag_bank.sv ***
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin cmpCount++; if ((got) !== (ex)) begin errors++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module tb_amp_event_flag_bank
    import amp_event_flag_pkg::*;
;
    typedef struct {string name; logic [7:0] val;} note_t;
    // raw event order: register two bits first, then register three bits
    localparam int POS [13] = '{HEAT_WARN_LVL2_START_BIT, HEAT_WARN_LVL2_STOP_BIT,
        SPEAKER_MONITOR_FAULT_BIT, CLOCK_MONITOR_FAULT_BIT, PORT_CLOCK_RECOVER_BIT,
        PORT_CLOCK_FAULT_BIT, PORT_DATA_FAULT_BIT, POWERUP_COMPLETE_BIT,
        POWERDOWN_COMPLETE_BIT, HV_SUPPLY_UNDERVOLT_BIT, BATTERY_UNDERVOLT_BIT,
        HEADROOM_TRACK_START_BIT, HEADROOM_TRACK_STOP_BIT};
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [12:0] raw = '0;
    logic [7:0] clearTwo = 8'h00;
    logic [7:0] clearThree = 8'h00;
    logic irqEnable = 1'b0;
    logic [15:0] regAddr = 16'h0000;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [7:0] regWdata = 8'h00;
    logic [7:0] regRdata, eventFlagsTwo, eventFlagsThree;
    logic irq;
    logic rdPend = 1'b0;
    note_t expQ [$];
    note_t note;
    int errors = 0;
    int cmpCount = 0;
    int irqSeen = 0;

    amp_event_flag_bank i_amp_event_flag_bank (.core_clk(core_clk), .rst_b(rst_b),
        .heatWarnLvl2StartRaw(raw[0]), .heatWarnLvl2StopRaw(raw[1]),
        .speakerMonitorFaultRaw(raw[2]), .clockMonitorFaultRaw(raw[3]),
        .portClockRecoverRaw(raw[4]), .portClockFaultRaw(raw[5]),
        .portDataFaultRaw(raw[6]), .powerupCompleteRaw(raw[7]),
        .powerdownCompleteRaw(raw[8]), .hvSupplyUndervoltRaw(raw[9]),
        .batteryUndervoltRaw(raw[10]), .headroomTrackStartRaw(raw[11]),
        .headroomTrackStopRaw(raw[12]), .clearTwo(clearTwo), .clearThree(clearThree),
        .irqEnable(irqEnable), .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
        .regWdata(regWdata), .regRdata(regRdata), .eventFlagsTwo(eventFlagsTwo),
        .eventFlagsThree(eventFlagsThree), .irq(irq));

    // 50 MHz clock
    initial begin
        forever #10 core_clk = ~core_clk;
    end

    task automatic tick;
        @(posedge core_clk);
        #1;
    endtask

    // an idle cycle after each access keeps strobes from being reassigned in one step
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        regAddr = a;
        regWdata = d;
        regWrite = 1'b1;
        tick;
        regWrite = 1'b0;
        tick;
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] e, input string s);
        regAddr = a;
        regRead = 1'b1;
        expQ.push_back('{s, e});
        tick;
        regRead = 1'b0;
        tick;
    endtask

    // read data lands one edge after the strobe, so compare on the edge after that
    always @(posedge core_clk) begin
        if (rdPend) begin
            note = expQ.pop_front();
            `CHK(note.name, note.val, regRdata)
        end
        rdPend <= regRead;
    end

    // interrupt pulses are counted mid-cycle, away from the edge that launches them
    always @(negedge core_clk) begin
        if (irq === 1'b1) irqSeen++;
    end

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", cmpCount, errors);
        if (errors == 0 && cmpCount > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // hang guard, the sequence needs well under two thousand cycles
    initial begin
        #100000;
        errors++;
        conclude();
    end

    initial begin
        logic [7:0] e, m2, m3;
        logic [15:0] fa;
        logic two;
        int n;
        void'($urandom(37));
        repeat (3) @(posedge core_clk);
        #1;
        rst_b = 1'b1;
        rd(ADDR_EVENT_FLAGS_TWO, RESET_FLAGS, "flags two reset");
        rd(ADDR_EVENT_FLAGS_THREE, RESET_FLAGS, "flags three reset");
        rd(ADDR_UNMASK_TWO, RESET_UNMASK, "unmask two reset");
        wr(ADDR_EVENT_FLAGS_TWO, 8'hff);
        wr(ADDR_EVENT_FLAGS_THREE, 8'hff);
        wr(16'h2013, 8'hff);
        rd(ADDR_EVENT_FLAGS_TWO, 8'h00, "flags two write");
        rd(ADDR_EVENT_FLAGS_THREE, 8'h00, "flags three write");
        rd(16'h2013, READ_UNMAPPED, "unmapped");
        // every event while masked must leave no trace
        raw = '1;
        tick;
        raw = '0;
        tick;
        rd(ADDR_EVENT_FLAGS_TWO, 8'h00, "masked two");
        rd(ADDR_EVENT_FLAGS_THREE, 8'h00, "masked three");
        wr(ADDR_UNMASK_TWO, 8'hff);
        wr(ADDR_UNMASK_THREE, 8'hff);
        rd(ADDR_UNMASK_TWO, VALID_TWO, "unmask two rw");
        rd(ADDR_UNMASK_THREE, VALID_THREE, "unmask three rw");
        irqEnable = 1'b1;
        // one event at a time: its own bit only, held past the raw pulse, own clear
        for (int i = 0; i < 13; i++) begin
            two = (i < 7);
            fa = two ? ADDR_EVENT_FLAGS_TWO : ADDR_EVENT_FLAGS_THREE;
            e = 8'h00;
            e[POS[i]] = 1'b1;
            n = irqSeen;
            raw[i] = 1'b1;
            tick;
            raw[i] = 1'b0;
            repeat (3) tick;
            rd(fa, e, "single");
            `CHK("irq count", n + 1, irqSeen)
            `CHK("flags 2 out", two ? e : 8'h00, eventFlagsTwo)
            `CHK("flags 3 out", two ? 8'h00 : e, eventFlagsThree)
            if (two) clearTwo[POS[i]] = 1'b1;
            else clearThree[POS[i]] = 1'b1;
            tick;
            clearTwo = 8'h00;
            clearThree = 8'h00;
            tick;
            rd(fa, 8'h00, "cleared");
        end
        // a rise in the clearing cycle must still set the flag
        e = 8'h00;
        e[PORT_DATA_FAULT_BIT] = 1'b1;
        n = irqSeen;
        clearTwo = e;
        raw[6] = 1'b1;
        tick;
        clearTwo = 8'h00;
        raw[6] = 1'b0;
        tick;
        rd(ADDR_EVENT_FLAGS_TWO, e, "set wins");
        `CHK("irq set wins", n + 1, irqSeen)
        // dropping the unmask bit empties the flag at once
        wr(ADDR_UNMASK_TWO, 8'h00);
        rd(ADDR_EVENT_FLAGS_TWO, 8'h00, "unmask drop");
        // random masks and interrupt enable against all events at once
        for (int k = 0; k < 20; k++) begin
            m2 = 8'($urandom());
            m3 = 8'($urandom());
            irqEnable = 1'($urandom());
            wr(ADDR_UNMASK_TWO, m2);
            wr(ADDR_UNMASK_THREE, m3);
            n = irqSeen;
            raw = '1;
            tick;
            raw = '0;
            repeat (2) tick;
            rd(ADDR_EVENT_FLAGS_TWO, m2 & VALID_TWO, "random two");
            rd(ADDR_EVENT_FLAGS_THREE, m3 & VALID_THREE, "random three");
            n += (irqEnable && ((m2 & VALID_TWO) | (m3 & VALID_THREE)) != 8'h00) ? 1 : 0;
            `CHK("irq random", n, irqSeen)
            clearTwo = 8'hff;
            clearThree = 8'hff;
            tick;
            clearTwo = 8'h00;
            clearThree = 8'h00;
            tick;
            rd(ADDR_EVENT_FLAGS_TWO, 8'h00, "random clear");
        end
        // a reset in mid-run empties flags and unmask registers alike
        wr(ADDR_UNMASK_TWO, 8'hff);
        raw[0] = 1'b1;
        tick;
        raw[0] = 1'b0;
        rst_b = 1'b0;
        tick;
        rst_b = 1'b1;
        rd(ADDR_EVENT_FLAGS_TWO, RESET_FLAGS, "flags after reset");
        rd(ADDR_UNMASK_TWO, RESET_UNMASK, "unmask after reset");
        repeat (3) tick;
        conclude();
    end
endmodule
